//--- seg_lcd_pkg.sv
// Constants, register map and field layout of the segment display controller.
`default_nettype none

package seg_lcd_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] PHASE_OFS    = 8'h04;
  localparam logic [7:0] IRQ_OFS      = 8'h08;
  localparam logic [7:0] SEGEN_LO_OFS = 8'h0c;
  localparam logic [7:0] SEGEN_HI_OFS = 8'h10;
  localparam logic [7:0] PIX_BASE_OFS = 8'h20;
  localparam logic [7:0] PIX_LAST_OFS = 8'h3c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_SLP_BIT  = 6;
  localparam int CTRL_WRITE_ERROR_FLAG_BIT = 5;
  localparam int CTRL_CS_LSB   = 2;
  localparam int CTRL_MUX_LSB  = 0;
  localparam int PH_TYPEB_BIT  = 7;
  localparam int PH_ACTIVE_BIT = 5;
  localparam int PH_WOK_BIT    = 4;
  localparam int PH_PRE_LSB    = 0;
  localparam int IRQ_FLAG_BIT  = 0;
  localparam int IRQ_EN_BIT    = 1;

  // ****************************************
  // Sizes and encodings
  // ****************************************
  localparam int NUM_SEG   = 46;
  localparam int NUM_COM   = 4;
  localparam int SEG_HI_W  = 14;
  localparam int PIX_WORDS = 8;

  localparam logic [1:0] SRC_SYSDIV4 = 2'b00;
  localparam logic [1:0] SRC_TIMER1  = 2'b01;
  localparam logic [1:0] SRC_LFOSC   = 2'b10;
  localparam logic [1:0] MUX_STATIC  = 2'b00;

  // ****************************************
  // Reset values, divider end and phase counts
  // ****************************************
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [3:0]  PRE_RST   = 4'h0;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [1:0]  SYS_DIV_LAST = 2'h3;
  localparam logic [2:0]  FRAME_IRQ_LEAD_PHASES    = 3'h1;
  localparam logic [2:0]  DATA_WRITE_WINDOW_PHASES = 3'h1;

endpackage : seg_lcd_pkg

`default_nettype wire

//--- seg_lcd_phase_tick.sv
// Clock source selection and prescaler giving one pulse per phase interval.
`timescale 1ns/1ps
`default_nettype none

module seg_lcd_phase_tick
  import seg_lcd_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] clk_src,
  input  wire logic [3:0] frame_prescale,
  // Oscillator pins
  input  wire logic       t1_osc_in,
  input  wire logic       lf_osc_in,
  // Phase enable
  output logic            phase_tick
);

  logic [2:0] t1_sync_q;
  logic [2:0] lf_sync_q;
  logic [1:0] div_q;
  logic [3:0] pre_q;
  logic       src_tick;

  // ****************************************
  // Oscillator synchronisers and edge detect
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t1_sync_q <= 3'h0;
      lf_sync_q <= 3'h0;
    end
    else
    begin
      t1_sync_q <= {t1_sync_q[1:0], t1_osc_in};
      lf_sync_q <= {lf_sync_q[1:0], lf_osc_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end

  always_comb
  begin
    case (clk_src)
      SRC_SYSDIV4: src_tick = (div_q == SYS_DIV_LAST);
      SRC_TIMER1:  src_tick = t1_sync_q[1] & ~t1_sync_q[2];
      default:     src_tick = lf_sync_q[1] & ~lf_sync_q[2];
    endcase
  end

  // ****************************************
  // Prescaler
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q      <= 4'h0;
      phase_tick <= 1'b0;
    end
    else
    begin
      phase_tick <= 1'b0;
      if (!run)
        pre_q <= 4'h0;
      else if (src_tick)
      begin
        if (pre_q >= frame_prescale)
        begin
          pre_q      <= 4'h0;
          phase_tick <= 1'b1;
        end
        else
          pre_q <= pre_q + 4'h1;
      end
    end
  end

endmodule : seg_lcd_phase_tick

`default_nettype wire

//--- segment_lcd_frame_irq_sleep_ctrl.sv
// Segment display frame timing, interrupt flag, shutdown and sleep control with APB registers.
`timescale 1ns/1ps
`default_nettype none

module segment_lcd_frame_irq_sleep_ctrl
  import seg_lcd_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Processor sleep
  input  wire logic               sleep_exec,
  output logic                    wake_req,
  // Oscillator pins
  input  wire logic               t1_osc_in,
  input  wire logic               lf_osc_in,
  // Display lines
  output logic [NUM_COM-1:0]      com_drive,
  output logic [NUM_SEG-1:0]      seg_drive,
  output logic                    wave_polarity,
  output logic                    pins_lcd_mode,
  output logic                    lines_grounded,
  output logic                    frame_start,
  output logic                    display_irq_flag
);

  logic                en_q;
  logic                slp_sel_q;
  logic                write_error_flag_q;
  logic [1:0]          cs_q;
  logic [1:0]          mux_q;
  logic                typeb_q;
  logic [3:0]          pre_q;
  logic                fie_q;
  logic [31:0]         segen_lo_q;
  logic [SEG_HI_W-1:0] segen_hi_q;
  logic [31:0]         pix_q [PIX_WORDS];
  logic [NUM_SEG-1:0]  shadow_q [NUM_COM];
  logic                active_q;
  logic [2:0]          phase_q;
  logic                odd_q;
  logic                win_q;
  logic                phase_tick;
  logic                frame_due_q;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [2:0] last_phase(input logic [1:0] mux, input logic typeb);
    last_phase = typeb ? {1'b0, mux} : {mux, 1'b1};
  endfunction : last_phase

  function automatic logic [NUM_SEG-1:0] pix_row(input logic [31:0] lo, input logic [31:0] hi);
    pix_row = {hi[SEG_HI_W-1:0], lo};
  endfunction : pix_row

  // ****************************************
  // Decoded state
  // ****************************************
  logic       frame_irq_mode;
  logic       halt;
  logic       run;
  logic       asleep_running;
  logic       boundary;
  logic       write_ok;
  logic       wr_fire;
  logic       setup;
  logic       is_pix;
  logic [2:0] pix_idx;
  logic [2:0] last;
  logic [1:0] com_idx;

  assign frame_irq_mode = typeb_q & (mux_q != MUX_STATIC);
  // Sleep halts the sequencer unless a slow oscillator keeps it running with shutdown clear.
  assign halt           = sleep_exec & (slp_sel_q | (cs_q == SRC_SYSDIV4));
  assign asleep_running = sleep_exec & ~slp_sel_q & (cs_q != SRC_SYSDIV4);
  assign run            = active_q & ~halt;
  assign last           = last_phase(mux_q, typeb_q);
  assign boundary       = run & phase_tick & (phase_q == last);
  assign com_idx        = typeb_q ? phase_q[1:0] : phase_q[2:1];
  // No writes while running asleep; otherwise free while stopped or outside irq mode, and in irq mode only inside the window.
  assign write_ok       = ~asleep_running & (~active_q | ~frame_irq_mode | win_q);
  assign setup          = psel & ~penable;
  assign wr_fire        = psel & penable & pwrite & pready;
  assign is_pix         = (paddr >= PIX_BASE_OFS) && (paddr <= PIX_LAST_OFS) && (paddr[1:0] == 2'h0);
  assign pix_idx        = paddr[4:2];

  seg_lcd_phase_tick u_tick (
    .pclk           (pclk),
    .presetn        (presetn),
    .run            (run),
    .clk_src        (cs_q),
    .frame_prescale (pre_q),
    .t1_osc_in      (t1_osc_in),
    .lf_osc_in      (lf_osc_in),
    .phase_tick     (phase_tick)
  );

  // ****************************************
  // APB answer
  // ****************************************
  // Every transfer gets exactly one access cycle; read data stands only while ready is high.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= WORD_RST;
    end
    else
    begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= WORD_RST;
      if (setup)
      begin
        case (paddr)
          CTRL_OFS:     prdata <= {24'h0, en_q, slp_sel_q, write_error_flag_q, 1'b0, cs_q, mux_q};
          PHASE_OFS:    prdata <= {24'h0, typeb_q, 1'b0, active_q, write_ok, pre_q};
          IRQ_OFS:      prdata <= {30'h0, fie_q, display_irq_flag};
          SEGEN_LO_OFS: prdata <= segen_lo_q;
          SEGEN_HI_OFS: prdata <= {{(32-SEG_HI_W){1'b0}}, segen_hi_q};
          default:
          begin
            if (is_pix)
              prdata <= pix_q[pix_idx];
            else
              pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {en_q, slp_sel_q} <= CTRL_RST[7:6];
      cs_q              <= CTRL_RST[3:2];
      mux_q             <= CTRL_RST[1:0];
      typeb_q           <= 1'b0;
      pre_q             <= PRE_RST;
      fie_q             <= 1'b0;
      segen_lo_q        <= WORD_RST;
      segen_hi_q        <= WORD_RST[SEG_HI_W-1:0];
    end
    else if (wr_fire)
    begin
      case (paddr)
        CTRL_OFS:
        begin
          en_q      <= pwdata[CTRL_EN_BIT];
          slp_sel_q <= pwdata[CTRL_SLP_BIT];
          cs_q      <= pwdata[CTRL_CS_LSB +: 2];
          mux_q     <= pwdata[CTRL_MUX_LSB +: 2];
        end
        PHASE_OFS:
        begin
          typeb_q <= pwdata[PH_TYPEB_BIT];
          pre_q   <= pwdata[PH_PRE_LSB +: 4];
        end
        IRQ_OFS:      fie_q      <= pwdata[IRQ_EN_BIT];
        SEGEN_LO_OFS: segen_lo_q <= pwdata;
        SEGEN_HI_OFS: segen_hi_q <= pwdata[SEG_HI_W-1:0];
        default:      fie_q      <= fie_q;
      endcase
    end
  end

  // ****************************************
  // Pixel data and write error
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < PIX_WORDS; i++)
        pix_q[i] <= WORD_RST;
    end
    else if (wr_fire && is_pix && write_ok)
      pix_q[pix_idx] <= pix_idx[0] ? {{(32-SEG_HI_W){1'b0}}, pwdata[SEG_HI_W-1:0]} : pwdata;
  end

  // A blocked pixel write sets the error bit, and a set beats a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      write_error_flag_q <= 1'b0;
    else if (wr_fire && is_pix && !write_ok)
      write_error_flag_q <= 1'b1;
    else if (wr_fire && paddr == CTRL_OFS)
      write_error_flag_q <= write_error_flag_q & pwdata[CTRL_WRITE_ERROR_FLAG_BIT];
  end

  // ****************************************
  // Active flag and frame sequencing
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_q <= 1'b0;
    else if (en_q)
      active_q <= 1'b1;
    else if (boundary)
      active_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= 3'h0;
      odd_q   <= 1'b0;
    end
    else if (!active_q)
    begin
      phase_q <= 3'h0;
      odd_q   <= 1'b0;
    end
    else if (boundary)
    begin
      phase_q <= 3'h0;
      odd_q   <= ~odd_q;
    end
    else if (run && phase_tick)
      phase_q <= phase_q + 3'h1;
  end

  // A frame is due on the first common right after a boundary or a fresh start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_due_q <= 1'b0;
    else
      frame_due_q <= boundary | (en_q & ~active_q);
  end

  // Window opens one phase before the boundary, only at the end of a frame pair.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      win_q <= 1'b0;
    else if (!active_q || boundary)
      win_q <= 1'b0;
    else if (run && phase_tick && frame_irq_mode && odd_q
             && (phase_q == last - DATA_WRITE_WINDOW_PHASES))
      win_q <= 1'b1;
  end

  // Pixel data is fetched for the whole frame at its first common edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < NUM_COM; c++)
        shadow_q[c] <= '0;
    end
    else if (boundary || (en_q && !active_q))
    begin
      for (int c = 0; c < NUM_COM; c++)
        shadow_q[c] <= pix_row(pix_q[2*c], pix_q[2*c+1]);
    end
  end

  // ****************************************
  // Interrupt flag and wake
  // ****************************************
  // Both interrupt sources share one flag, and a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      display_irq_flag <= 1'b0;
    else if (active_q && !en_q && boundary)
      display_irq_flag <= 1'b1;
    else if (run && phase_tick && frame_irq_mode && odd_q
             && (phase_q == last - FRAME_IRQ_LEAD_PHASES))
      display_irq_flag <= 1'b1;
    else if (wr_fire && paddr == IRQ_OFS && pwdata[IRQ_FLAG_BIT])
      display_irq_flag <= 1'b0;
  end

  // Wake is a one-cycle pulse at the frame boundary while the display keeps running asleep.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_req <= 1'b0;
    else
      wake_req <= asleep_running & fie_q & frame_irq_mode & boundary;
  end

  // ****************************************
  // Line drive
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      com_drive      <= '0;
      seg_drive      <= '0;
      wave_polarity  <= 1'b0;
      pins_lcd_mode  <= 1'b0;
      lines_grounded <= 1'b0;
      frame_start    <= 1'b0;
    end
    else
    begin
      frame_start    <= 1'b0;
      lines_grounded <= active_q & sleep_exec & slp_sel_q;
      pins_lcd_mode  <= active_q;
      if (!active_q || (sleep_exec && slp_sel_q))
      begin
        com_drive     <= '0;
        seg_drive     <= '0;
        wave_polarity <= 1'b0;
      end
      else if (run)
      begin
        frame_start   <= frame_due_q;
        com_drive     <= 4'h1 << com_idx;
        wave_polarity <= typeb_q ? odd_q : phase_q[0];
        seg_drive     <= shadow_q[com_idx] & pix_row(segen_lo_q, {18'h0, segen_hi_q});
      end
    end
  end

endmodule : segment_lcd_frame_irq_sleep_ctrl

`default_nettype wire

//--- seg_lcd_asserts.sv
// Concurrent checks on the ports of the segment display controller.
`timescale 1ns/1ps
`default_nettype none

module seg_lcd_asserts
  import seg_lcd_pkg::*;
(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Register bus
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  // Sleep and display lines
  input wire logic               sleep_exec,
  input wire logic               wake_req,
  input wire logic [NUM_COM-1:0] com_drive,
  input wire logic [NUM_SEG-1:0] seg_drive,
  input wire logic               pins_lcd_mode,
  input wire logic               lines_grounded,
  input wire logic               frame_start,
  input wire logic               display_irq_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_com_one_hot: assert property ($onehot0(com_drive))
    else $error("several commons active");
  a_frame_at_com: assert property (frame_start |-> com_drive == 1)
    else $error("frame start off first common");
  a_frame_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame start too long");
  a_ground_quiet: assert property (lines_grounded && $past(lines_grounded)
    |-> com_drive == '0 && seg_drive == '0)
    else $error("lines driven while grounded");
  a_shutdown_irq: assert property ($fell(pins_lcd_mode) && !lines_grounded
    |-> display_irq_flag)
    else $error("no flag at shutdown");
  a_flag_sticky: assert property (display_irq_flag
    && !(psel && penable && pwrite && paddr == IRQ_OFS) |=> display_irq_flag)
    else $error("flag lost");
  a_wake_pulse: assert property (wake_req |-> $past(sleep_exec) ##1 !wake_req)
    else $error("bad wake pulse");
endmodule : seg_lcd_asserts

bind segment_lcd_frame_irq_sleep_ctrl seg_lcd_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
  .wake_req(wake_req), .com_drive(com_drive), .seg_drive(seg_drive),
  .pins_lcd_mode(pins_lcd_mode), .lines_grounded(lines_grounded),
  .frame_start(frame_start), .display_irq_flag(display_irq_flag));

`default_nettype wire

//--- lcd_glass_model.sv
// Passive glass model that counts frames and keeps the first common's picture.
`timescale 1ns/1ps
`default_nettype none

module lcd_glass_model
  import seg_lcd_pkg::*;
(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Display lines
  input wire logic [NUM_COM-1:0] com_drive,
  input wire logic [NUM_SEG-1:0] seg_drive,
  input wire logic               frame_start,
  // Observed picture
  output logic [NUM_SEG-1:0]     first_common_line_segs,
  output logic [15:0]            frame_count
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      frame_count <= '0;
    else if (frame_start)
      frame_count <= frame_count + 16'h0001;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      first_common_line_segs <= '0;
    else if (com_drive[0])
      first_common_line_segs <= seg_drive;
endmodule : lcd_glass_model

`default_nettype wire

//--- test_segment_lcd_frame_irq_sleep_ctrl.sv
// Self-checking bench for the segment display controller.
`timescale 1ns/1ps
`default_nettype none

module test_segment_lcd_frame_irq_sleep_ctrl import seg_lcd_pkg::*;;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, sleep_exec, t1_osc_in, lf_osc_in, err, pol0;
  logic pready, pslverr, wake_req, wave_polarity, pins_lcd_mode, lines_grounded;
  logic frame_start, display_irq_flag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_COM-1:0] com_drive, c;
  logic [NUM_SEG-1:0] seg_drive, first_common_line_segs;
  logic [15:0] frame_count;
  int fail_count, checked, cyc, i;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_s;
  row_s rows [11] = '{'{0, CTRL_OFS, 0, 0, 0}, '{0, PHASE_OFS, 0, 32'h10, 0},
    '{0, IRQ_OFS, 0, 0, 0}, '{1, SEGEN_LO_OFS, '1, 0, 0}, '{0, SEGEN_LO_OFS, 0, '1, 0},
    '{1, SEGEN_HI_OFS, '1, 0, 0}, '{0, SEGEN_HI_OFS, 0, 32'h3fff, 0},
    '{1, PIX_BASE_OFS, 32'ha5a5a5a5, 0, 0}, '{0, PIX_BASE_OFS, 0, 32'ha5a5a5a5, 0},
    '{1, 8'h14, 1, 0, 1}, '{0, 8'h14, 0, 0, 1}};

  segment_lcd_frame_irq_sleep_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec), .wake_req(wake_req),
    .t1_osc_in(t1_osc_in), .lf_osc_in(lf_osc_in), .com_drive(com_drive),
    .seg_drive(seg_drive), .wave_polarity(wave_polarity), .pins_lcd_mode(pins_lcd_mode),
    .lines_grounded(lines_grounded), .frame_start(frame_start),
    .display_irq_flag(display_irq_flag));
  lcd_glass_model u_glass (.pclk(pclk), .presetn(presetn), .com_drive(com_drive),
    .seg_drive(seg_drive), .frame_start(frame_start), .first_common_line_segs(first_common_line_segs),
    .frame_count(frame_count));

  always #2 pclk = ~pclk;

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from assigning psel twice at once.
    @(posedge pclk);
  endtask : apb

  task rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, rd, x);
  endtask : rdc

  task end_sim;
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Slow oscillator pins and the run limit.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc % 10 == 0)
      t1_osc_in <= ~t1_osc_in;
    if (cyc % 3 == 0)
      lf_osc_in <= ~lf_osc_in;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {presetn, psel, penable, pwrite, sleep_exec, t1_osc_in, lf_osc_in} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 11; i++)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("rdata", rd, rows[i].x);
      chk("slverr", {31'h0, err}, {31'h0, rows[i].e});
    end
    // Type-A, four commons, then shutdown.
    apb(1, CTRL_OFS, 32'h83);
    rdc("active", PHASE_OFS, 32'h30);
    while (frame_count < 3) @(posedge pclk);
    chk("first_common_line", first_common_line_segs[31:0], 32'ha5a5a5a5);
    chk("a irq", {31'h0, display_irq_flag}, 0);
    apb(1, CTRL_OFS, 0);
    while (pins_lcd_mode !== 1'b0) @(posedge pclk);
    @(posedge pclk);
    chk("down irq", {31'h0, display_irq_flag}, 1);
    chk("pins", {28'h0, com_drive}, 0);
    rdc("idle", PHASE_OFS, 32'h10);
    apb(1, IRQ_OFS, 1);
    rdc("cleared", IRQ_OFS, 0);
    // Type-B, four commons: write window and blocked write.
    apb(1, PHASE_OFS, 32'h80);
    apb(1, IRQ_OFS, 2);
    apb(1, CTRL_OFS, 32'h83);
    while (display_irq_flag !== 1'b1) @(posedge pclk);
    apb(1, PIX_BASE_OFS, 32'h0f0f0f0f);
    while (frame_start !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    pol0 = wave_polarity;
    apb(1, PIX_BASE_OFS, 32'h12345678);
    rdc("kept", PIX_BASE_OFS, 32'h0f0f0f0f);
    rdc("write_error_flag", CTRL_OFS, 32'ha3);
    while (frame_start !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    chk("polarity", {31'h0, wave_polarity}, {31'h0, ~pol0});
    // Sleep with the display running on the slow oscillator.
    apb(1, IRQ_OFS, 3);
    apb(1, CTRL_OFS, 32'h8b);
    sleep_exec <= 1'b1;
    apb(1, PIX_BASE_OFS, 32'h0);
    while (wake_req !== 1'b1) @(posedge pclk);
    sleep_exec <= 1'b0;
    rdc("sleep pix", PIX_BASE_OFS, 32'h0f0f0f0f);
    rdc("sleep write_error_flag", CTRL_OFS, 32'hab);
    // Type-B static drive gives no frame interrupt.
    apb(1, CTRL_OFS, 32'h80);
    repeat (40) @(posedge pclk);
    apb(1, IRQ_OFS, 3);
    repeat (40) @(posedge pclk);
    chk("static irq", {31'h0, display_irq_flag}, 0);
    // Sleep on the system clock halts the lines.
    apb(1, CTRL_OFS, 32'h83);
    sleep_exec <= 1'b1;
    repeat (2) @(posedge pclk);
    c = com_drive;
    repeat (40) @(posedge pclk);
    chk("halted", {28'h0, com_drive}, {28'h0, c});
    sleep_exec <= 1'b0;
    // Sleep with shutdown selected grounds every line.
    apb(1, CTRL_OFS, 32'hc3);
    sleep_exec <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("ground", {27'h0, lines_grounded, com_drive}, 32'h10);
    chk("ground seg", seg_drive[31:0], 0);
    // Reset in mid-run.
    presetn <= 1'b0;
    sleep_exec <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("rst", {28'h0, pins_lcd_mode, lines_grounded, display_irq_flag, wake_req}, 0);
    presetn <= 1'b1;
    rdc("rst ctrl", CTRL_OFS, 0);
    end_sim();
  end
endmodule : test_segment_lcd_frame_irq_sleep_ctrl

`default_nettype wire
